//--- bench/sar_host_model.sv
/*
  Host serial port model: drives select and a 48 ns serial clock,
  captures the data line on falling and on rising clock edges.
  Frames start on a falling system clock edge, off the sampling edge.
  Assumes the readout sequencer's pins are wired to it directly.
*/
`timescale 1ns/1ps
module sar_host_model (
  // Bench clock for aligning frames
  input wire logic clk,
  // Host drive
  output logic convSelect_b,
  output logic serialBitClk,
  // Device data line
  input wire logic serialResultOut,
  input wire logic serialResultOe
);
  localparam int HALF_NS = 24;
  localparam int SETTLE_NS = 30;
  logic lastDriven;
  logic dataLine;
  logic [15:0] riseBits;

  // Idle pins; clock stands high outside frames
  initial begin
    convSelect_b = 1'b1;
    serialBitClk = 1'b1;
    lastDriven = 1'b0;
  end

  // Remember the last bit the device drove
  always @(serialResultOut or serialResultOe) begin
    if (serialResultOe) begin
      lastDriven = serialResultOut;
    end
  end

  // Released line shows the inverse of the last driven bit
  assign dataLine = serialResultOe ? serialResultOut : ~lastDriven;

  // Slow host variant: capture on rising clock edges as well
  always @(posedge serialBitClk) begin
    riseBits = {riseBits[14:0], dataLine};
  end

  // One frame: select low, nClk clock pulses, select high, then the gap
  task automatic frame(input int nClk, output logic [15:0] bits, output logic oeStart,
                       output logic oeEnd, output logic oeRise);
    @(negedge clk);
    bits = 16'h0000;
    riseBits = 16'h0000;
    convSelect_b = 1'b0;
    #(SETTLE_NS);
    oeStart = serialResultOe;
    for (int k = 0; k < nClk; k++) begin
      bits = {bits[14:0], dataLine};
      serialBitClk = 1'b0;
      #(HALF_NS);
      serialBitClk = 1'b1;
      #(HALF_NS);
    end
    oeEnd = serialResultOe;
    convSelect_b = 1'b1;
    #(SETTLE_NS);
    oeRise = serialResultOe;
    #(10 * HALF_NS);
  endtask : frame
endmodule : sar_host_model

//--- bench/sar_readout_tb_top.sv
/*
  Self-checking bench of the readout sequencer in its 12-bit form, with
  10- and 8-bit copies sharing the host pins and the core stream.
  Assumes the host model file is compiled before this one.
*/
`timescale 1ns/1ps
module sar_readout_tb_top;
  localparam int RES = 12;
  logic clk, rst_b, resultValid, resultReady, holdMode, poweredUp, convAbort;
  logic convSelect_b, serialBitClk, serialResultOut, serialResultOe;
  logic [RES-1:0] resultData;
  logic holdSeen, oeS, oeE, oeR, holdAtRise, hold8AtRise, oe8AtRise;
  logic out10, out8, oe8, hold8, abort10, abort8;
  logic [2:0] abortSeen;
  logic [15:0] bits, bits10, bits8;
  int failures;
  int totalChecks;

  // System clock 200 MHz
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  sar_readout #(.RES(RES), .DEPTH(8)) u_dut (.clk(clk), .rst_b(rst_b),
    .convSelect_b(convSelect_b), .serialBitClk(serialBitClk),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
    .resultValid(resultValid), .resultReady(resultReady), .resultData(resultData),
    .holdMode(holdMode), .poweredUp(poweredUp), .convAbort(convAbort));

  // Narrower variants on the same pins and stream
  sar_readout #(.RES(10), .DEPTH(8)) u_dut10 (.clk(clk), .rst_b(rst_b),
    .convSelect_b(convSelect_b), .serialBitClk(serialBitClk),
    .serialResultOut(out10), .serialResultOe(),
    .resultValid(resultValid), .resultReady(), .resultData(resultData[11:2]),
    .holdMode(), .poweredUp(), .convAbort(abort10));

  sar_readout #(.RES(8), .DEPTH(8)) u_dut8 (.clk(clk), .rst_b(rst_b),
    .convSelect_b(convSelect_b), .serialBitClk(serialBitClk),
    .serialResultOut(out8), .serialResultOe(oe8),
    .resultValid(resultValid), .resultReady(), .resultData(resultData[11:4]),
    .holdMode(hold8), .poweredUp(), .convAbort(abort8));

  sar_host_model u_host (.clk(clk), .convSelect_b(convSelect_b),
    .serialBitClk(serialBitClk),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe));

  // Sticky record of the abort pulses: bit 0 wide, 1 ten-bit, 2 eight-bit
  always @(posedge clk) begin
    abortSeen <= abortSeen | {abort8 === 1'b1, abort10 === 1'b1, convAbort === 1'b1};
  end

  // Clear narrow captures, then hold state shortly after each select fall
  always @(negedge convSelect_b) begin
    bits10 = 16'h0000;
    bits8 = 16'h0000;
    #28;
    holdSeen = holdMode;
  end

  // Narrow variants captured on falling clock edges like the host
  always @(negedge serialBitClk) begin
    bits10 = {bits10[14:0], out10};
    bits8 = {bits8[14:0], out8};
  end

  // Hold and enable just before select rises
  always @(posedge convSelect_b) begin
    holdAtRise = holdMode;
    hold8AtRise = hold8;
    oe8AtRise = oe8;
  end

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Hand one word to the buffer over valid/ready
  task automatic push(input logic [RES-1:0] w);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    resultValid = 1'b1;
    resultData = w;
    while (resultReady !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("pushReady", 16'(n < 20), 16'h0001);
    @(posedge clk);
    #1;
    resultValid = 1'b0;
  endtask : push

  // Full 16-clock frame carries zeros then the word
  task automatic t_full_frame();
    abortSeen = 3'h0;
    push(12'hA53);
    u_host.frame(16, bits, oeS, oeE, oeR);
    check("frameBits", bits, {4'h0, 12'hA53});
    check("riseBits", {1'b0, u_host.riseBits[15:1]}, {4'h0, 12'hA53});
    check("bits10", bits10, {4'h0, 10'h294, 2'h0});
    check("bits8", bits8, {4'h0, 8'hA5, 4'h0});
    check("trackBeforeRise", 16'(holdAtRise), 16'h0000);
    check("track8BeforeRise", 16'(hold8AtRise), 16'h0000);
    check("oe8At16", 16'(oe8AtRise), 16'h0000);
    check("oeAtStart", 16'(oeS), 16'h0001);
    check("holdAtStart", 16'(holdSeen), 16'h0001);
    check("oeAfter16", 16'(oeE), 16'h0000);
    check("trackAtEnd", 16'(holdMode), 16'h0000);
    check("noAbort", 16'(abortSeen), 16'h0000);
  endtask : t_full_frame

  // Select rise after 12 clocks aborts but keeps power
  task automatic t_abort_late();
    abortSeen = 3'h0;
    push(12'h3C5);
    u_host.frame(12, bits, oeS, oeE, oeR);
    check("partBits", bits, 16'h003C);
    check("oeBeforeRise", 16'(oeE), 16'h0001);
    check("oeAfterRise", 16'(oeR), 16'h0000);
    check("abortPulse", 16'(abortSeen), 16'h0003);
    check("stillUp", 16'(poweredUp), 16'h0001);
    check("bits10Part", bits10, 16'h003C);
    check("bits8Full", bits8, {8'h00, 8'h3C});
    check("holdAtEarlyRise", 16'(holdAtRise), 16'h0001);
    check("track8At12", 16'(hold8AtRise), 16'h0000);
  endtask : t_abort_late

  // Power-down window, glitch guards and wake-up
  task automatic t_power();
    u_host.frame(1, bits, oeS, oeE, oeR);
    check("upAfterOne", 16'(poweredUp), 16'h0001);
    u_host.frame(8, bits, oeS, oeE, oeR);
    check("downAfterBurst", 16'(poweredUp), 16'h0000);
    check("oeAfterBurst", 16'(oeR), 16'h0000);
    repeat (600) @(posedge clk);
    u_host.frame(5, bits, oeS, oeE, oeR);
    check("stayDown", 16'(poweredUp), 16'h0000);
    u_host.frame(16, bits, oeS, oeE, oeR);
    check("wokeUp", 16'(poweredUp), 16'h0001);
  endtask : t_power

  // Fill the buffer until it refuses, then drain it frame by frame
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) push(12'h801 + 12'(i) * 12'h111);
    @(posedge clk);
    #1;
    check("fullRefuse", 16'(resultReady), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      u_host.frame(16, bits, oeS, oeE, oeR);
      check("drainBits", bits, {4'h0, 12'h801 + 12'(i) * 12'h111});
    end
    u_host.frame(16, bits, oeS, oeE, oeR);
    check("emptyFrame", bits, 16'h0000);
    check("readyAgain", 16'(resultReady), 16'h0001);
  endtask : t_fifo

  // Verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    rst_b = 1'b0;
    resultValid = 1'b0;
    resultData = '0;
    failures = 0;
    totalChecks = 0;
    abortSeen = 3'h0;
    holdSeen = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("rstOe", 16'(serialResultOe), 16'h0000);
    check("rstPower", 16'(poweredUp), 16'h0001);
    t_full_frame();
    t_abort_late();
    t_power();
    t_fifo();
    report_and_stop();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule : sar_readout_tb_top

//--- verilog/sar_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/1ps
module sar_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = sar_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstQ_b,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } sar_fifo_st_t;

  sar_fifo_st_t st_q;
  sar_fifo_st_t st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWrite;
  logic doRead;

  // Full when pointers differ only in the wrap bit
  assign inReady = !((st_q.wrPtr[AW] != st_q.rdPtr[AW]) &&
                     (st_q.wrPtr[AW-1:0] == st_q.rdPtr[AW-1:0]));
  assign outValid = (st_q.wrPtr != st_q.rdPtr);
  assign outData = mem[st_q.rdPtr[AW-1:0]];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Pointer update
  always_comb begin
    st_d = st_q;
    if (doWrite) begin
      st_d.wrPtr = st_q.wrPtr + 1'b1;
    end
    if (doRead) begin
      st_d.rdPtr = st_q.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstQ_b) begin
    if (!rstQ_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage array, written without reset
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[st_q.wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule : sar_fifo

//--- verilog/sar_pkg.sv
/*
  Shared constants of the converter readout sequencer: frame lengths,
  power-mode thresholds and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sar_pkg;

  // Frame shape
  localparam int FRAME_CLKS = 16;
  localparam int LEAD_ZEROS = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  // Conversion length in clock cycles per resolution
  localparam logic [4:0] CONV_CLKS_12 = 5'h10;
  localparam logic [4:0] CONV_CLKS_10 = 5'h0E;
  localparam logic [4:0] CONV_CLKS_8 = 5'h0C;

  // Falling edges after which hold returns to track
  localparam logic [4:0] TRACK_AFTER_WIDE = 5'h0D;
  localparam logic [4:0] TRACK_AFTER_8 = 5'h0B;

  // Falling-edge counts for tri-state and power decisions
  localparam logic [4:0] TRISTATE_EDGE = 5'h10;
  localparam logic [4:0] PD_WIN_LOW = 5'h02;
  localparam logic [4:0] PD_WIN_HIGH = 5'h0A;
  localparam logic [4:0] FULL_PWR_EDGE = 5'h10;

  // Reset values
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [4:0] CNT_RST = 5'h00;

  // FIFO defaults
  localparam int FIFO_DEPTH = 8;

  // Power state of the analog core
  typedef enum logic [1:0] {PWR_UP, PWR_DOWN, PWR_WAKING} sar_pwr_t;

endpackage : sar_pkg

//--- verilog/sar_readout.sv
/*
  Conversion and serial readout sequencer of a 12/10/8-bit SAR converter.
  The host's select and serial clock pins are sampled by clk; their edges
  drive sampling, hold/track, frame output and power management.
  Assumes clk runs well above four times the serial clock rate and the
  converter core hands finished words in through the buffer port.

  // Operation
  // RULE_01 - Select falling samples input, enters hold, drives data line, starts conversion.
  // RULE_02 - Host serial clock is the conversion clock and paces result bits.
  // RULE_03 - 12-bit: 16 cycles; after 13 falls, track on next rise.
  // RULE_04 - 12-bit: data line released on 16th falling clock edge.
  // RULE_05 - 12-bit: select rising before 16 cycles aborts and releases line.
  // RULE_06 - 10-bit: 14 cycles; track on rise after 13th fall.
  // RULE_07 - 10-bit: early rise before 14 aborts; 16 clocks release at 16th fall.
  // RULE_08 - 8-bit: 12 cycles; track on rise after 11th fall.
  // RULE_09 - 8-bit: early rise before 12 aborts; 16 clocks release at 16th fall.
  // RULE_10 - Select fall shows first leading zero; each clock fall shifts next bit.
  // RULE_11 - 12-bit: last bit shifted on 15th fall, valid at 16th.
  // RULE_12 - Slow host may capture on rising edges, missing first zero.
  // RULE_13 - Select falling just after a clock fall still shows first zero.
  // RULE_14 - 8-bit: host may end frame at 12th rise for fastest rate.
  // RULE_15 - Host keeps acquisition and quiet intervals between frames.
  // RULE_16 - Host enters power-down with an eight-clock burst frame.
  // RULE_17 - 10-bit in 16-cycle frame ends with two trailing zeros.
  // RULE_18 - Result shifted most significant bit first.
  // RULE_19 - Power-down between conversions only useful at low throughput.
  // RULE_20 - Host spaces select falls by whole clock periods.
  // RULE_21 - Select rise between 2nd and 10th fall aborts and powers down.
  // RULE_22 - Powered down: low past 10th fall wakes; full at 16 clocks.
  // RULE_23 - Select rise after 10th fall before end keeps power, aborts, releases.
  // RULE_24 - Host waits quiet interval after release before next select fall.
  // RULE_25 - Frame is four leading zeros then the result bits.
  // RULE_26 - Falling-edge counter cleared on each select fall, steers decisions.
*/
`timescale 1ns/1ps
module sar_readout #(
  parameter int RES = 12,
  parameter int DEPTH = sar_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host serial pins
  input wire logic convSelect_b,
  input wire logic serialBitClk,
  output logic serialResultOut,
  output logic serialResultOe,
  // Converter core result stream
  input wire logic resultValid,
  output logic resultReady,
  input wire logic [RES-1:0] resultData,
  // Analog control and status
  output logic holdMode,
  output logic poweredUp,
  output logic convAbort
);

  // Conversion length for a resolution
  function automatic logic [4:0] convClks(input int r);
    if (r == 12) begin
      return sar_pkg::CONV_CLKS_12;
    end else if (r == 10) begin
      return sar_pkg::CONV_CLKS_10;
    end else begin
      return sar_pkg::CONV_CLKS_8;
    end
  endfunction : convClks

  // Falling edges after which hold returns to track
  function automatic logic [4:0] trackAfter(input int r);
    if (r == 8) begin
      return sar_pkg::TRACK_AFTER_8;
    end else begin
      return sar_pkg::TRACK_AFTER_WIDE;
    end
  endfunction : trackAfter

  localparam logic [4:0] CONV_LEN = convClks(RES);
  localparam logic [4:0] TRACK_AT = trackAfter(RES);
  localparam int TAIL = sar_pkg::FRAME_CLKS - sar_pkg::LEAD_ZEROS - RES;

  typedef struct packed {
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic ckMeta;
    logic ckSync;
    logic ckPrev;
    logic framing;
    logic [4:0] fallCnt;
    logic [15:0] shift;
    logic dataOut;
    logic dataOe;
    logic hold;
    sar_pkg::sar_pwr_t pwr;
    logic abort;
  } sar_st_t;

  sar_st_t st_q;
  sar_st_t st_d;
  logic [1:0] rstSync_q;
  logic rstQ_b;
  logic csFall;
  logic csRise;
  logic ckFall;
  logic ckRise;
  logic popValid;
  logic [RES-1:0] popData;
  logic [15:0] loadWord;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstQ_b = rstSync_q[1];

  // Pin edges from the second synchroniser stage only
  assign csFall = st_q.csPrev && !st_q.csSync;
  assign csRise = !st_q.csPrev && st_q.csSync;
  assign ckFall = st_q.ckPrev && !st_q.ckSync;
  assign ckRise = !st_q.ckPrev && st_q.ckSync;

  // Result buffer between converter core and readout
  sar_fifo #(
    .WIDTH(RES),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstQ_b(rstQ_b),
    .inValid(resultValid),
    .inReady(resultReady),
    .inData(resultData),
    .outValid(popValid),
    .outReady(csFall),
    .outData(popData)
  );

  // Frame word: leading zeros, result MSB first, trailing zeros
  assign loadWord = popValid ? (16'(popData) << TAIL) : 16'h0000; // see RULE_25 RULE_17 RULE_18

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    st_d.csMeta = convSelect_b;
    st_d.csSync = st_q.csMeta;
    st_d.csPrev = st_q.csSync;
    st_d.ckMeta = serialBitClk;
    st_d.ckSync = st_q.ckMeta;
    st_d.ckPrev = st_q.ckSync;
    st_d.abort = 1'b0;
    if (csFall) begin
      // Sample, hold, drive the first leading zero
      st_d.framing = 1'b1; // see RULE_01 RULE_02
      st_d.fallCnt = sar_pkg::CNT_RST; // see RULE_26
      st_d.shift = loadWord;
      st_d.dataOut = loadWord[15]; // see RULE_10 RULE_13
      st_d.dataOe = 1'b1; // see RULE_01
      st_d.hold = 1'b1;
    end else if (st_q.framing && csRise) begin
      // Frame ends; early end aborts the conversion
      st_d.framing = 1'b0;
      st_d.dataOe = 1'b0; // see RULE_05 RULE_07 RULE_09 RULE_23
      st_d.abort = (st_q.fallCnt < CONV_LEN); // see RULE_05 RULE_07 RULE_09 RULE_14
      if (st_q.pwr == sar_pkg::PWR_UP && st_q.fallCnt >= sar_pkg::PD_WIN_LOW &&
          st_q.fallCnt < sar_pkg::PD_WIN_HIGH) begin
        st_d.pwr = sar_pkg::PWR_DOWN; // see RULE_21
      end else if (st_q.pwr == sar_pkg::PWR_WAKING) begin
        st_d.pwr = sar_pkg::PWR_UP; // see RULE_22
      end
      st_d.hold = (st_d.pwr == sar_pkg::PWR_DOWN);
    end else if (st_q.framing && ckFall) begin
      // Count edges and shift the next bit out
      if (st_q.fallCnt != sar_pkg::CNT_MAX) begin
        st_d.fallCnt = st_q.fallCnt + 5'h01; // see RULE_26
      end
      st_d.shift = {st_q.shift[14:0], 1'b0};
      st_d.dataOut = st_q.shift[14]; // see RULE_10 RULE_11 RULE_18
      if (st_d.fallCnt == sar_pkg::TRISTATE_EDGE) begin
        st_d.dataOe = 1'b0; // see RULE_04 RULE_07 RULE_09
      end
      if (st_q.pwr == sar_pkg::PWR_DOWN && st_d.fallCnt == sar_pkg::PD_WIN_HIGH) begin
        st_d.pwr = sar_pkg::PWR_WAKING; // see RULE_22
      end else if (st_q.pwr == sar_pkg::PWR_WAKING &&
                   st_d.fallCnt == sar_pkg::FULL_PWR_EDGE) begin
        st_d.pwr = sar_pkg::PWR_UP; // see RULE_22
      end
      if (st_q.pwr == sar_pkg::PWR_DOWN) begin
        st_d.hold = 1'b0;
      end
    end else if (st_q.framing && ckRise) begin
      // Back to track once the bit decisions are done
      if (st_q.fallCnt >= TRACK_AT || st_q.pwr == sar_pkg::PWR_DOWN) begin
        st_d.hold = 1'b0; // see RULE_03 RULE_06 RULE_08
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstQ_b) begin
    if (!rstQ_b) begin
      st_q.csMeta <= 1'b1;
      st_q.csSync <= 1'b1;
      st_q.csPrev <= 1'b1;
      st_q.ckMeta <= 1'b1;
      st_q.ckSync <= 1'b1;
      st_q.ckPrev <= 1'b1;
      st_q.framing <= 1'b0;
      st_q.fallCnt <= sar_pkg::CNT_RST;
      st_q.shift <= sar_pkg::SHIFT_RST;
      st_q.dataOut <= 1'b0;
      st_q.dataOe <= 1'b0;
      st_q.hold <= 1'b0;
      st_q.pwr <= sar_pkg::PWR_UP;
      st_q.abort <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops, except poweredUp, decoded from the power state
  assign serialResultOut = st_q.dataOut;
  assign serialResultOe = st_q.dataOe;
  assign holdMode = st_q.hold;
  assign poweredUp = (st_q.pwr == sar_pkg::PWR_UP);
  assign convAbort = st_q.abort;

  // Select fall drives the first leading zero and holds
  frame_start_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_01
    csFall |=> serialResultOe && !serialResultOut && holdMode && st_q.fallCnt == 5'h00)
    else $error("frame start did not drive zero in hold");

  // Early select rise releases the line and flags abort
  early_abort_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_05
    (st_q.framing && csRise && !csFall && st_q.fallCnt < CONV_LEN)
      |=> !serialResultOe && convAbort ##1 !convAbort)
    else $error("early select rise did not abort");

  // Sixteenth falling edge releases the line
  release_16_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_04
    (st_q.framing && ckFall && !csFall && !csRise && st_q.fallCnt == 5'h0F)
      |=> !serialResultOe)
    else $error("line still driven after 16th fall");

  // Each falling edge presents the next shifted bit
  bit_shift_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_10
    (st_q.framing && ckFall && !csFall && !csRise)
      |=> serialResultOut == $past(st_q.shift[14]) && st_q.fallCnt != 5'h00)
    else $error("shifted bit mismatch");

  // Rise inside the window enters power-down
  pd_entry_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_21
    (st_q.framing && csRise && !csFall && st_q.pwr == sar_pkg::PWR_UP &&
     st_q.fallCnt >= 5'h02 && st_q.fallCnt <= 5'h09) |=> !poweredUp && holdMode)
    else $error("power-down not entered");

  // Rise before second edge or after tenth keeps power
  pd_glitch_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_23
    (st_q.framing && csRise && !csFall && st_q.pwr == sar_pkg::PWR_UP &&
     (st_q.fallCnt < 5'h02 || st_q.fallCnt >= 5'h0A)) |=> poweredUp && !serialResultOe)
    else $error("power lost outside the window");

  // Tenth falling edge while down starts wake-up
  wake_start_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_22
    (st_q.framing && ckFall && !csFall && !csRise && st_q.pwr == sar_pkg::PWR_DOWN &&
     st_q.fallCnt == 5'h09) |=> st_q.pwr == sar_pkg::PWR_WAKING)
    else $error("wake-up did not start");

  // Track after the last bit decision
  track_return_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_03
    (st_q.framing && ckRise && !csFall && !csRise && !ckFall && st_q.fallCnt >= TRACK_AT)
      |=> !holdMode)
    else $error("hold not released after conversion");

  // Counter never moves without an edge inside a frame
  count_hold_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_26
    (!csFall && !(st_q.framing && ckFall)) |=> $stable(st_q.fallCnt))
    else $error("edge counter moved without an edge");

  // A frame that reached its conversion length ends without abort
  full_length_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_14
    (st_q.framing && csRise && !csFall && st_q.fallCnt >= CONV_LEN)
      |=> !convAbort && !serialResultOe)
    else $error("complete frame flagged as abort");

  // Abort lasts a single cycle
  abort_pulse_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_05
    convAbort |=> !convAbort)
    else $error("abort pulse longer than one cycle");

  // Data line is released whenever no frame is open
  idle_release_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_23
    !st_q.framing |-> !serialResultOe)
    else $error("data line driven outside a frame");

  // Clock edges outside a frame leave data and count alone
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_02
    (!st_q.framing && !csFall)
      |=> $stable(serialResultOut) && $stable(st_q.fallCnt))
    else $error("state moved outside a frame");

  // Loaded frame word opens with four zeros
  lead_zeros_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_25
    csFall |=> st_q.shift[15:12] == 4'h0)
    else $error("frame word without leading zeros");

  // Result sits right after the zeros, MSB first
  msb_load_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_18
    (csFall && popValid)
      |=> st_q.shift[11 -: RES] == $past(popData))
    else $error("result not loaded MSB first");

  // Empty buffer gives an all-zero frame
  empty_frame_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_25
    (csFall && !popValid) |=> st_q.shift == 16'h0000)
    else $error("empty buffer frame not zero");

  // Powered-down frame returns to track on its first clock edge
  down_track_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_22
    (st_q.framing && ckFall && !csFall && !csRise && st_q.pwr == sar_pkg::PWR_DOWN)
      |=> !holdMode)
    else $error("hold kept during power-down frame");

  // Sixteenth fall while waking completes power-up
  full_power_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_22
    (st_q.framing && ckFall && !csFall && !csRise && st_q.pwr == sar_pkg::PWR_WAKING &&
     st_q.fallCnt == 5'h0F) |=> poweredUp)
    else $error("not fully powered after 16 clocks");

  // Early rise while down stays powered down in hold
  stay_down_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_22
    (st_q.framing && csRise && !csFall && st_q.pwr == sar_pkg::PWR_DOWN)
      |=> !poweredUp && holdMode && !serialResultOe)
    else $error("woke up on a short frame");

  // Hold kept until the bit decisions are done
  early_hold_a: assert property (@(posedge clk) disable iff (!rstQ_b) // see RULE_03
    (st_q.framing && ckRise && !csFall && !csRise && st_q.fallCnt < TRACK_AT &&
     st_q.pwr == sar_pkg::PWR_UP) |=> $stable(holdMode))
    else $error("track entered too early");

endmodule : sar_readout
